// >>> shared/mtrh_pkg.sv
`default_nettype none
package mtrh_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RESP_MS = 5;
  localparam int unsigned RESP_CYC = RESP_MS * 1000 * CLK_MHZ;
  localparam logic [15:0] TCP_PORT = 16'h01f6; // Filtered by the stack ahead of us
  localparam logic [15:0] PROTO_ID = 16'h0000;
  localparam int unsigned HDR_LEN = 7;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INP = 8'h04;
  localparam logic [7:0] FC_WR_ONE = 8'h06;
  localparam logic [7:0] FC_WR_MUL = 8'h10;
  localparam logic [7:0] FC_RD_LOG = 8'h64;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FC = 8'h01;
  localparam logic [15:0] LOG_BASE = 16'h6000;
  localparam logic [15:0] LOG_RECS = 16'h1f40;
  localparam logic [7:0] LOG_BYTES = 8'h3e;
  localparam int unsigned MAX_FRAME = 260;
endpackage
`default_nettype wire

// >>> shared/mtrh_reg_if.sv
`default_nettype none
interface mtrh_reg_if;
  logic rd;
  logic wr;
  logic log_sel;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output rd, output wr, output log_sel, output addr, output wdata, input rdata);
  modport port (input rd, input wr, input log_sel, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> rtl/mtrh_reg_port.sv
`default_nettype none
module mtrh_reg_port (
  input wire logic clk_i,
  input wire logic rst_b_i,
  mtrh_reg_if.port bus,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_log_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i
);
  // Registered read data; requester waits one cycle
  logic [15:0] rdata_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 16'h0000;
    end else if (bus.rd) begin
      rdata_reg <= mem_rdata_i;
    end
  end
  assign bus.rdata = rdata_reg;
  assign mem_rd_o = bus.rd;
  assign mem_wr_o = bus.wr;
  assign mem_log_o = bus.log_sel;
  assign mem_addr_o = bus.addr;
  assign mem_wdata_o = bus.wdata;
endmodule
`default_nettype wire

// >>> rtl/mtrh_resp_timer.sv
`default_nettype none
module mtrh_resp_timer #(
  parameter int unsigned LIMIT = mtrh_pkg::RESP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic stop_i,
  output logic late_o
);
  logic [31:0] cnt_reg;
  logic run_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_reg <= 1'b0;
    end else if (start_i) begin
      run_reg <= 1'b1;
    end else if (stop_i) begin
      run_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 32'h0000_0000;
    end else if (start_i) begin
      cnt_reg <= 32'h0000_0000;
    end else if (run_reg && cnt_reg != 32'(LIMIT)) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end
  // Budget for the whole answer
  assign late_o = run_reg && (cnt_reg == 32'(LIMIT));
endmodule
`default_nettype wire

// >>> rtl/mtrh_handler.sv
`default_nettype none
module mtrh_handler #(
  parameter int unsigned RESP_LIMIT = mtrh_pkg::RESP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_log_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  output logic late_o,
  output logic drop_o
);
  typedef enum logic [4:0] {
    ST_RX = 5'h01, ST_CHK = 5'h02, ST_MEM = 5'h04, ST_WAIT = 5'h08, ST_TX = 5'h10
  } mtrh_state_t;

  localparam int unsigned MAXF = mtrh_pkg::MAX_FRAME;
  mtrh_state_t state_reg;
  logic [7:0] rxb [MAXF];
  logic [7:0] txb [MAXF];
  logic [8:0] rx_cnt_reg;
  logic [8:0] tx_len_reg;
  logic [8:0] tx_idx_reg;
  logic [8:0] wpos_reg;
  logic [15:0] idx_reg;
  logic drop_reg;
  mtrh_reg_if rif ();

  // Header fields, high byte first
  logic [15:0] f_proto, f_len, f_addr, f_qty;
  logic [7:0] f_fc;
  assign f_proto = {rxb[2], rxb[3]};
  assign f_len = {rxb[4], rxb[5]};
  assign f_fc = rxb[7];
  assign f_addr = {rxb[8], rxb[9]};
  assign f_qty = {rxb[10], rxb[11]};

  logic fc_known, is_read, is_log;
  assign is_read = (f_fc == mtrh_pkg::FC_RD_HOLD) || (f_fc == mtrh_pkg::FC_RD_INP);
  assign is_log = (f_fc == mtrh_pkg::FC_RD_LOG);
  assign fc_known = is_read || is_log || (f_fc == mtrh_pkg::FC_WR_ONE)
    || (f_fc == mtrh_pkg::FC_WR_MUL);

  // Length counts everything after its own field
  logic len_ok;
  assign len_ok = (rx_cnt_reg >= 9'(mtrh_pkg::HDR_LEN + 1))
    && (f_len == 16'(rx_cnt_reg) - 16'h0006);
  logic frame_ok;
  assign frame_ok = (f_proto == mtrh_pkg::PROTO_ID) && len_ok;

  // Count of data words to move; log reads yield 31 words per record
  logic [15:0] n_words;
  always_comb begin
    n_words = 16'h0000;
    if (is_read || f_fc == mtrh_pkg::FC_WR_MUL) begin
      n_words = f_qty;
    end else if (f_fc == mtrh_pkg::FC_WR_ONE) begin
      n_words = 16'h0001;
    end else if (is_log) begin
      n_words = 16'(f_qty * 16'(mtrh_pkg::LOG_BYTES >> 1));
    end
  end

  assign rx_ready_o = (state_reg == ST_RX);
  logic rx_take, tx_take, late;
  assign rx_take = rx_valid_i && rx_ready_o;
  assign tx_take = tx_valid_o && tx_ready_i;

  always_ff @(posedge clk_i) begin
    if (rx_take && rx_cnt_reg < 9'(MAXF)) begin
      rxb[rx_cnt_reg] <= rx_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_cnt_reg <= 9'h000;
    end else if (rx_take) begin
      rx_cnt_reg <= (rx_cnt_reg < 9'(MAXF)) ? rx_cnt_reg + 9'h001 : rx_cnt_reg;
    end else if (state_reg == ST_CHK) begin
      rx_cnt_reg <= 9'h000;
    end
  end

  // Word being moved: register address, or log record address
  logic [15:0] cur_addr;
  assign cur_addr = is_log ? (f_addr + (idx_reg / 16'(mtrh_pkg::LOG_BYTES >> 1)))
    : (f_addr + idx_reg);
  logic is_write;
  assign is_write = (f_fc == mtrh_pkg::FC_WR_ONE) || (f_fc == mtrh_pkg::FC_WR_MUL);
  logic [8:0] src_pos;
  assign src_pos = (f_fc == mtrh_pkg::FC_WR_ONE) ? 9'h00a : 9'(13 + 2 * idx_reg);
  logic log_in_range;
  assign log_in_range = (cur_addr >= mtrh_pkg::LOG_BASE)
    && (cur_addr < mtrh_pkg::LOG_BASE + mtrh_pkg::LOG_RECS);

  assign rif.rd = (state_reg == ST_MEM) && !is_write && !(is_log && !log_in_range);
  // Writes only for known write codes
  assign rif.wr = (state_reg == ST_MEM) && is_write && fc_known;
  assign rif.log_sel = is_log;
  assign rif.addr = is_log ? (cur_addr - mtrh_pkg::LOG_BASE) : cur_addr;
  assign rif.wdata = {rxb[src_pos], rxb[src_pos + 9'h001]};

  mtrh_reg_port u_port (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .bus(rif.port),
    .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o),
    .mem_log_o(mem_log_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i)
  );

  // Response builder; header echoes ids
  always_ff @(posedge clk_i) begin
    if (state_reg == ST_CHK && frame_ok) begin
      txb[0] <= rxb[0];
      txb[1] <= rxb[1];
      txb[2] <= mtrh_pkg::PROTO_ID[15:8];
      txb[3] <= mtrh_pkg::PROTO_ID[7:0];
      txb[6] <= rxb[6];
      if (!fc_known) begin
        txb[7] <= f_fc | mtrh_pkg::EXC_FLAG;
        txb[8] <= mtrh_pkg::EXC_ILL_FC;
        txb[4] <= 8'h00;
        txb[5] <= 8'h03;
      end else begin
        txb[7] <= f_fc;
        if (is_read || is_log) begin
          txb[8] <= 8'(n_words << 1);
          txb[4] <= 8'(16'(n_words << 1) + 16'h0003 >> 8);
          txb[5] <= 8'(16'(n_words << 1) + 16'h0003);
        end else begin
          // Write replies repeat the request from its length field on
          txb[4] <= rxb[4];
          txb[5] <= rxb[5];
          for (int k = 8; k < MAXF; k++) begin
            txb[k] <= rxb[k];
          end
        end
      end
    end else if (state_reg == ST_WAIT) begin
      // Both bytes of every word, log records included
      txb[wpos_reg] <= rif.rdata[15:8];
      txb[wpos_reg + 9'h001] <= rif.rdata[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_RX;
      idx_reg <= 16'h0000;
      wpos_reg <= 9'h000;
      tx_len_reg <= 9'h000;
      drop_reg <= 1'b0;
    end else begin
      drop_reg <= 1'b0;
      unique case (state_reg)
        ST_RX: begin
          if (rx_take && rx_last_i) begin
            state_reg <= ST_CHK;
          end
        end
        ST_CHK: begin
          idx_reg <= 16'h0000;
          wpos_reg <= 9'h009;
          if (!frame_ok) begin
            drop_reg <= 1'b1;
            state_reg <= ST_RX;
          end else if (!fc_known) begin
            tx_len_reg <= 9'h009;
            state_reg <= ST_TX;
          end else if (is_write) begin
            tx_len_reg <= rx_cnt_reg;
            state_reg <= ST_MEM;
          end else begin
            tx_len_reg <= 9'(9 + 2 * n_words);
            state_reg <= (n_words == 16'h0000) ? ST_TX : ST_MEM;
          end
        end
        ST_MEM: begin
          if (is_write) begin
            idx_reg <= idx_reg + 16'h0001;
            if (idx_reg + 16'h0001 >= n_words) begin
              state_reg <= ST_TX;
            end
          end else begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          idx_reg <= idx_reg + 16'h0001;
          wpos_reg <= wpos_reg + 9'h002;
          state_reg <= (idx_reg + 16'h0001 >= n_words) ? ST_TX : ST_MEM;
        end
        ST_TX: begin
          if (tx_take && tx_last_o) begin
            state_reg <= ST_RX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_idx_reg <= 9'h000;
    end else if (state_reg != ST_TX) begin
      tx_idx_reg <= 9'h000;
    end else if (tx_take) begin
      tx_idx_reg <= tx_idx_reg + 9'h001;
    end
  end

  // Out-of-range log words carry stale data; no access is made
  assign tx_valid_o = (state_reg == ST_TX);
  assign tx_data_o = txb[tx_idx_reg];
  assign tx_last_o = tx_valid_o && (tx_idx_reg + 9'h001 == tx_len_reg);
  assign drop_o = drop_reg;

  mtrh_resp_timer #(.LIMIT(RESP_LIMIT)) u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(state_reg == ST_CHK && frame_ok),
    .stop_i(tx_take && tx_last_o),
    .late_o(late)
  );
  assign late_o = late;

  // Checks on drops, writes, log reads, and the reply buffer as it is built and while it leaves
  AST_DROP_SILENT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == ST_CHK && !frame_ok) |=> (state_reg == ST_RX) [*2])
    else $error("Bad frame was not dropped");
  AST_NO_WR_UNKNOWN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == ST_CHK && frame_ok && !fc_known) |=> !mem_wr_o [*3])
    else $error("Unknown code wrote a register");
  AST_TID_ECHO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == ST_CHK && frame_ok) |=> (txb[0] == $past(rxb[0])))
    else $error("Transaction id not echoed");
  AST_UID_ECHO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == ST_CHK && frame_ok) |=> (txb[6] == $past(rxb[6])))
    else $error("Unit id not echoed");
  AST_PROTO_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && tx_idx_reg == 9'h002) |-> (tx_data_o == 8'h00))
    else $error("Protocol id nonzero");
  AST_LEN_FIELD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && tx_idx_reg == 9'h000) |-> ({txb[4], txb[5]} == 16'(tx_len_reg) - 16'h0006))
    else $error("Length field wrong");
  AST_WR_ECHO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && f_fc == mtrh_pkg::FC_WR_ONE) |-> (tx_len_reg == 9'h00c))
    else $error("Single write reply length wrong");
  AST_BYTECOUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && is_read) |-> (txb[8] == 8'(f_qty << 1)))
    else $error("Byte count wrong");
  // Only a stalled sink may hold the reply past its budget
  AST_IN_TIME: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    late_o |-> tx_valid_o)
    else $error("Budget spent before reply was offered");
  AST_WR_LEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && f_fc == mtrh_pkg::FC_WR_MUL) |-> (tx_len_reg == 9'(f_len + 16'h0006)))
    else $error("Multiple write reply length wrong");
  AST_RD_LEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && is_read) |-> (tx_len_reg == 9'(9 + 2 * f_qty)))
    else $error("Read reply length wrong");
  AST_EXC_REPLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && !fc_known)
    |-> (tx_len_reg == 9'h009 && txb[7] == (f_fc | mtrh_pkg::EXC_FLAG)))
    else $error("Exception reply wrong");
  AST_LOG_RANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mem_rd_o && mem_log_o) |-> (mem_addr_o < mtrh_pkg::LOG_RECS))
    else $error("Log record index out of range");
  AST_TX_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && !tx_ready_i) |=> (tx_valid_o && $stable(tx_data_o)))
    else $error("Reply byte changed before taken");
  AST_DROP_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drop_o |=> !drop_o)
    else $error("Drop pulse too long");
  AST_FC_ECHO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_valid_o && fc_known && tx_idx_reg == 9'h007) |-> (tx_data_o == f_fc))
    else $error("Function code not echoed");
  AST_ONE_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == ST_CHK && frame_ok && f_fc == mtrh_pkg::FC_WR_ONE) |=> mem_wr_o ##1 !mem_wr_o)
    else $error("Single write not one strobe");
  AST_WR_DATA: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mem_wr_o && f_fc == mtrh_pkg::FC_WR_ONE) |-> (mem_wdata_o == f_qty))
    else $error("Single write value wrong");
endmodule
`default_nettype wire

// >>> testbench/mtrh_client.sv
`default_nettype none
module mtrh_client #(
  parameter int GAP = 20
) (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_last_o,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
  end
  // Sink takes bytes promptly or slowly
  always @(posedge clk_i) begin
    tx_ready_o <= !stall_i && ($urandom_range(3) != 0);
  end
  task automatic send(input logic [7:0] f[$]);
    // Scaled stand-in for the request and packet spacing
    repeat (GAP) @(posedge clk_i);
    for (int i = 0; i < f.size(); i++) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= f[i];
      rx_last_o <= (i == f.size() - 1);
      @(posedge clk_i);
      while (!rx_ready_i) @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    // Stale data would hide a sampling slip
    rx_data_o <= ~f[f.size() - 1];
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t %s", $time, m); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 400;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic stall = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic mem_rd, mem_wr, mem_log, late, drop;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int num_errors = 0;
  int n_checks = 0;
  int n_drop = 0;
  int n_log = 0;
  int cyc = 0;
  bit in_late = 0;
  logic [9:0] eq[$];
  logic [9:0] e;
  logic [31:0] wq[$];
  logic [7:0] fcs[5] = '{mtrh_pkg::FC_RD_HOLD, mtrh_pkg::FC_RD_INP, mtrh_pkg::FC_WR_ONE,
    mtrh_pkg::FC_WR_MUL, mtrh_pkg::FC_RD_LOG};
  always #5 clk_i = ~clk_i;
  assign mem_rdata = mem_addr ^ 16'h5a3c;
  mtrh_handler #(.RESP_LIMIT(LIM)) u_mtrh_handler (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_last_i(rx_last), .rx_ready_o(rx_ready),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_log_o(mem_log), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .late_o(late), .drop_o(drop));
  mtrh_client #(.GAP(20)) u_mtrh_client (.clk_i(clk_i), .stall_i(stall), .rx_ready_i(rx_ready),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_last_o(rx_last), .tx_ready_o(tx_ready));
  task end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (rst_b_i && tx_valid && tx_ready) begin
      if (eq.size() == 0) `CHK(1'b0, 1'b1, "unexpected response byte")
      else begin
        e = eq.pop_front();
        if (!e[8]) `CHK(tx_data, e[7:0], "response byte")
        `CHK(tx_last, e[9], "frame end")
      end
    end
    if (rst_b_i && mem_wr) begin
      if (wq.size() == 0) `CHK(1'b0, 1'b1, "unexpected write")
      else `CHK({mem_addr, mem_wdata}, wq.pop_front(), "register write")
    end
    if (rst_b_i && drop) n_drop++;
    if (rst_b_i && mem_rd && mem_log) n_log++;
    if (cyc == 20000) begin
      num_errors++;
      $display("mismatch t=%0t timeout", $time);
      end_sim();
    end
  end
  task automatic xact(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
      input logic [15:0] pid, input int ladj, input string nm);
    logic [7:0] pdu[$], rp[$], req[$];
    logic [9:0] ex[$];
    logic [15:0] tid, v, len;
    logic [7:0] uid;
    int d0, l0, i, nl;
    bit lg, rng;
    tid = 16'($urandom);
    uid = 8'($urandom);
    d0 = n_drop;
    l0 = n_log;
    nl = 0;
    lg = (fc == mtrh_pkg::FC_RD_LOG);
    pdu = {fc, a[15:8], a[7:0], q[15:8], q[7:0]};
    if (fc == mtrh_pkg::FC_WR_MUL) begin
      pdu.push_back(8'(2 * q));
      for (int j = 0; j < q; j++) begin
        v = 16'($urandom);
        pdu.push_back(v[15:8]);
        pdu.push_back(v[7:0]);
        wq.push_back({a + 16'(j), v});
      end
    end
    if (fc == mtrh_pkg::FC_WR_ONE) wq.push_back({a, q});
    case (fc)
      mtrh_pkg::FC_RD_HOLD, mtrh_pkg::FC_RD_INP: begin
        rp = {fc, 8'(2 * q)};
        for (int j = 0; j < q; j++) begin
          v = (a + 16'(j)) ^ 16'h5a3c;
          rp.push_back(v[15:8]);
          rp.push_back(v[7:0]);
        end
      end
      mtrh_pkg::FC_WR_ONE, mtrh_pkg::FC_WR_MUL: rp = pdu;
      mtrh_pkg::FC_RD_LOG: rp = {fc, mtrh_pkg::LOG_BYTES};
      default: rp = {fc | mtrh_pkg::EXC_FLAG, mtrh_pkg::EXC_ILL_FC};
    endcase
    len = 16'(pdu.size() + 1 + ladj);
    req = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], uid};
    foreach (pdu[k]) req.push_back(pdu[k]);
    if (pid == 16'h0000 && ladj == 0) begin
      len = 16'(rp.size() + 1 + (lg ? 62 * q : 0));
      foreach (req[k]) if (k < 7) ex.push_back({2'b00, (k inside {2, 3}) ? 8'h00 : req[k]});
      ex[4] = {2'b00, len[15:8]};
      ex[5] = {2'b00, len[7:0]};
      foreach (rp[k]) ex.push_back({2'b00, rp[k]});
      // Stale words of out-of-range records are not compared
      if (lg) for (int r = 0; r < q; r++) begin
        v = a + 16'(r);
        rng = (v >= mtrh_pkg::LOG_BASE) && (v < mtrh_pkg::LOG_BASE + mtrh_pkg::LOG_RECS);
        if (rng) nl += 31;
        v = (v - mtrh_pkg::LOG_BASE) ^ 16'h5a3c;
        repeat (31) begin
          ex.push_back({1'b0, !rng, v[15:8]});
          ex.push_back({1'b0, !rng, v[7:0]});
        end
      end
      ex[ex.size() - 1][9] = 1'b1;
      eq = {eq, ex};
    end
    u_mtrh_client.send(req);
    for (i = 0; i < 2 * LIM && (eq.size() != 0 || i < 30); i++) @(posedge clk_i);
    `CHK(eq.size(), 0, "response incomplete")
    `CHK(wq.size(), 0, "write missing")
    `CHK(n_drop - d0, (pid != 16'h0000 || ladj != 0) ? 1 : 0, "drop count")
    if (lg) `CHK(n_log - l0, nl, "log word reads")
    if (!in_late) `CHK(late, 1'b0, "response budget")
    $display("test %s done", nm);
  endtask
  initial begin
    void'($urandom(32'h6f8e));
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (fcs[k]) begin
      if (fcs[k] == mtrh_pkg::FC_RD_LOG) begin
        xact(fcs[k], mtrh_pkg::LOG_BASE + 16'h1f3f, 16'h0001, 16'h0000, 0, "log read");
      end else if (fcs[k] == mtrh_pkg::FC_WR_ONE) begin
        xact(fcs[k], 16'($urandom_range(255)), 16'($urandom), 16'h0000, 0, "single write");
      end else begin
        xact(fcs[k], 16'($urandom_range(255)), 16'($urandom_range(1, 4)), 16'h0000, 0, "code");
      end
    end
    xact(mtrh_pkg::FC_RD_LOG, mtrh_pkg::LOG_BASE + mtrh_pkg::LOG_RECS, 16'h0001, 16'h0000, 0,
      "log range");
    xact(8'h2b, 16'h0001, 16'h0001, 16'h0000, 0, "unknown code");
    xact(8'h05, 16'h0001, 16'h0001, 16'h0000, 0, "unknown code");
    xact(mtrh_pkg::FC_RD_HOLD, 16'h0010, 16'h0001, 16'h0001, 0, "bad protocol");
    xact(mtrh_pkg::FC_RD_HOLD, 16'h0010, 16'h0001, 16'h0000, 1, "long length");
    xact(mtrh_pkg::FC_RD_HOLD, 16'h0010, 16'h0001, 16'h0000, -1, "short length");
    in_late = 1;
    stall <= 1'b1;
    fork
      xact(mtrh_pkg::FC_RD_INP, 16'h0201, 16'h0001, 16'h0000, 0, "late reply");
      begin
        repeat (LIM + 60) @(posedge clk_i);
        `CHK(late, 1'b1, "budget flag")
        stall <= 1'b0;
      end
    join
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(late, 1'b0, "late after reset")
    `CHK(tx_valid, 1'b0, "tx idle in reset")
    `CHK(rx_ready, 1'b1, "rx ready in reset")
    rst_b_i <= 1'b1;
    in_late = 0;
    xact(mtrh_pkg::FC_WR_MUL, 16'h0030, 16'h0003, 16'h0000, 0, "after reset");
    end_sim();
  end
endmodule
`default_nettype wire
